// file: inc/cco_pkg.sv
package cco_pkg;

  // Opcode word fields
  localparam int           OP_LINE_HI   = 15;
  localparam int           OP_LINE_LO   = 12;
  localparam int           OP_ID_HI     = 11;
  localparam int           OP_ID_LO     = 9;
  localparam int           OP_TYPE_HI   = 8;
  localparam int           OP_TYPE_LO   = 6;
  localparam int           OP_SUB_HI    = 8;
  localparam int           OP_SUB_LO    = 3;
  localparam int           OP_EA_HI     = 5;
  localparam int           OP_EA_LO     = 0;
  localparam int           OP_LOW_HI    = 2;
  localparam int           OP_LOW_LO    = 0;
  localparam logic [3:0]   LINE_COPROC  = 4'hf;
  localparam logic [2:0]   TYPE_SETBYTE = 3'h1;
  localparam logic [5:0]   SUB_DECBR    = 6'h09;
  localparam logic [5:0]   SUB_TRAP     = 6'h0f;
  localparam logic [2:0]   TRAP_ONE     = 3'h2;
  localparam logic [2:0]   TRAP_TWO     = 3'h3;
  localparam logic [2:0]   TRAP_ZERO    = 3'h4;

  // Effective address modes needing extension words
  localparam logic [2:0]   EA_DISP      = 3'h5;
  localparam logic [2:0]   EA_INDEX     = 3'h6;
  localparam logic [2:0]   EA_OTHER     = 3'h7;
  localparam logic [2:0]   EA_ABS_W     = 3'h0;
  localparam logic [2:0]   EA_ABS_L     = 3'h1;
  localparam int           EXT_FULL_BIT = 8;
  localparam int           EXT_BD_HI    = 5;
  localparam int           EXT_BD_LO    = 4;
  localparam int           EXT_OD_HI    = 1;
  localparam int           EXT_OD_LO    = 0;

  // Response primitive layout
  localparam int           RSP_AGAIN    = 15;
  localparam int           RSP_FUNC_HI  = 12;
  localparam int           RSP_FUNC_LO  = 8;
  localparam int           RSP_RESULT   = 0;
  localparam logic [4:0]   FUNC_NULL    = 5'h00;

  // Register map, byte addresses
  localparam logic [7:0]   REG_CTRL     = 8'h00;
  localparam logic [7:0]   REG_START    = 8'h04;
  localparam logic [7:0]   REG_CONFIG   = 8'h08;
  localparam logic [7:0]   REG_STATUS   = 8'h0c;
  localparam logic [7:0]   REG_EVENTS   = 8'h10;
  localparam logic [7:0]   REG_EVCLR    = 8'h14;
  localparam logic [7:0]   REG_EVEN     = 8'h18;
  localparam logic [7:0]   REG_NEXTPC   = 8'h1c;
  localparam logic [7:0]   REG_COUNT0   = 8'h20;
  localparam logic [2:0]   COUNT_MSB    = 3'h7;

  localparam int           EV_DONE      = 0;
  localparam int           EV_TRAP      = 1;
  localparam int           EV_PROTO     = 2;
  localparam int           EV_ILLEGAL   = 3;
  localparam int           EV_W         = 4;

  localparam logic [31:0]  START_RESET  = 32'h0000_0000;
  localparam logic [2:0]   CPEXT_RESET  = 3'h0;
  localparam logic [15:0]  COUNT_RESET  = 16'h0000;
  localparam logic [15:0]  COUNT_END    = 16'hffff;
  localparam logic [31:0]  WORD_STEP    = 32'h0000_0002;
  localparam logic [7:0]   BYTE_TRUE    = 8'hff;
  localparam logic [7:0]   BYTE_FALSE   = 8'h00;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_FOPC  = 9'h002,
    ST_DEC   = 9'h004,
    ST_FSEL  = 9'h008,
    ST_WCOND = 9'h010,
    ST_RRESP = 9'h020,
    ST_SVC   = 9'h040,
    ST_SKIP  = 9'h080,
    ST_DONE  = 9'h100
  } cco_state_e;

  typedef enum logic [2:0] {
    K_SETBYTE = 3'h1,
    K_DECBR   = 3'h2,
    K_TRAP    = 3'h4
  } cco_kind_e;

  typedef struct packed {
    logic        we;
    logic        resp;
    logic [15:0] data;
  } cco_cir_req_s;

  typedef struct packed {
    logic [5:0]  mode;
    logic [15:0] ext;
    logic [7:0]  value;
  } cco_flag_wr_s;

endpackage

// file: rtl/cco_coproc_cond.sv
// What this block does
// - F-line opcode, coprocessor id in 11..9
// - Type 001 in 8..6 selects set-byte
// - Low six bits give flag byte address mode
// - Selector word written whole to condition register
// - Coprocessor extension words counted and skipped
// - Up to five address extension words consumed
// - Read response register, serve until result
// - Non-null without come-again is protocol violation
// - False clears flag byte, true sets it
// - Sub-op 001001 is decrement-branch, 2..0 counter
// - Displacement word sign-extended to 32 bits
// - False decrements counter, branch unless minus one
// - Target is displacement word address plus offset
// - Sub-op 001111 is trap, 2..0 opmode
// - Opmode 010 one, 011 two, 100 zero words
// - Trap operand words skipped, not used
// - True traps, false continues
`timescale 1ns/10ps
`default_nettype none

module cco_coproc_cond
  import cco_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  output logic              irq,
  output logic              fetchReq,
  output logic      [31:0]  fetchAddr,
  input  wire logic         fetchAck,
  input  wire logic [15:0]  fetchData,
  output logic              cirReqValid,
  output cco_cir_req_s      cirReq,
  output logic      [2:0]   coprocIdentifier,
  input  wire logic         cirAck,
  input  wire logic [15:0]  cirRdata,
  output logic              serviceReq,
  output logic      [15:0]  servicePrim,
  input  wire logic         serviceDone,
  output logic              flagWrite,
  output cco_flag_wr_s      flagWr,
  output logic              trapStart,
  output logic              protoViolation,
  output logic              illegalInsn
);

  cco_state_e   state_q;
  cco_kind_e    kind_q;
  logic [15:0]  opWord_q;
  logic [31:0]  scanPtr_q;
  logic [31:0]  dispAddr_q;
  logic [15:0]  disp_q;
  logic [3:0]   remain_q;
  logic [3:0]   eaCnt_q;
  logic         result_q;
  logic [31:0]  startPc_q;
  logic [31:0]  nextPc_q;
  logic [2:0]   cpExt_q;
  logic [15:0]  count_q [8];
  logic [EV_W-1:0] events_q;
  logic [EV_W-1:0] evEnable_q;
  logic [EV_W-1:0] evSet;
  logic         busAccess;
  logic         busWrite;
  logic         startCmd;
  logic         countWrite;
  logic [15:0]  countNew;
  logic [2:0]   countSel;

  assign busAccess = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWrite  = busAccess && wb_we_i;
  assign startCmd  = busWrite && wb_adr_i == REG_CTRL && wb_sel_i[0]
                     && wb_dat_i[0] && state_q == ST_IDLE;

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Extension words of an alterable address mode, brief forms only;
  // the full index format adds words once its first word is seen
  function automatic logic [3:0] eaWords(input logic [5:0] ea);
    logic [3:0] n;
    n = 4'h0;
    if (ea[5:3] == EA_DISP || ea[5:3] == EA_INDEX) begin
      n = 4'h1;
    end else if (ea[5:3] == EA_OTHER && ea[2:0] == EA_ABS_W) begin
      n = 4'h1;
    end else if (ea[5:3] == EA_OTHER && ea[2:0] == EA_ABS_L) begin
      n = 4'h2;
    end
    return n;
  endfunction

  function automatic logic [3:0] sizeWords(input logic [1:0] sz);
    return (sz[1]) ? {3'h0, sz[0]} + 4'h1 : 4'h0;
  endfunction

  // Wishbone slave: one wait state, ack for exactly one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busAccess;
      wb_dat_o <= 32'h0000_0000;
      if (busAccess && !wb_we_i) begin
        if (wb_adr_i[7:5] == REG_COUNT0[7:5] && wb_adr_i[1:0] == 2'h0) begin
          wb_dat_o <= {16'h0000, count_q[wb_adr_i[4:2]]};
        end else begin
          unique case (wb_adr_i)
            REG_START:  wb_dat_o <= startPc_q;
            REG_CONFIG: wb_dat_o <= {29'h0, cpExt_q};
            REG_STATUS: wb_dat_o <= {15'h0, result_q, 4'h0, kind_q,
                                     state_q};
            REG_EVENTS: wb_dat_o <= {{(32-EV_W){1'b0}}, events_q};
            REG_EVEN:   wb_dat_o <= {{(32-EV_W){1'b0}}, evEnable_q};
            REG_NEXTPC: wb_dat_o <= nextPc_q;
            default:    wb_dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Software configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      startPc_q  <= START_RESET;
      cpExt_q    <= CPEXT_RESET;
      evEnable_q <= '0;
    end else if (busWrite) begin
      if (wb_adr_i == REG_START) begin
        startPc_q <= mergeBytes(startPc_q, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == REG_CONFIG && wb_sel_i[0]) begin
        cpExt_q <= wb_dat_i[2:0];
      end
      if (wb_adr_i == REG_EVEN && wb_sel_i[0]) begin
        evEnable_q <= wb_dat_i[EV_W-1:0];
      end
    end
  end

  // Loop counters; the sequencer wins over a software write that
  // lands in the same cycle, since it finishes the instruction
  generate
    for (genvar g = 0; g < 8; g++) begin : gCount
      always_ff @(posedge clock) begin
        if (rst) begin
          count_q[g] <= COUNT_RESET;
        end else if (countWrite && countSel == 3'(g)) begin
          count_q[g] <= countNew;
        end else if (busWrite && wb_adr_i == REG_COUNT0 + 8'(g * 4)) begin
          count_q[g] <= 16'(mergeBytes({16'h0000, count_q[g]}, wb_dat_i,
                                       wb_sel_i));
        end
      end
    end
  endgenerate

  // Events: set beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      events_q <= '0;
      irq      <= 1'b0;
    end else begin
      if (busWrite && wb_adr_i == REG_EVCLR && wb_sel_i[0]) begin
        events_q <= (events_q & ~wb_dat_i[EV_W-1:0]) | evSet;
      end else begin
        events_q <= events_q | evSet;
      end
      irq <= |(events_q & evEnable_q);
    end
  end

  assign evSet = {illegalInsn, protoViolation, trapStart,
                  state_q == ST_DONE};

  logic [15:0] cnt;
  logic        decDone;
  assign countSel   = opWord_q[OP_LOW_HI:OP_LOW_LO];
  assign cnt        = count_q[countSel] - 16'h0001;
  assign decDone    = cnt == COUNT_END;
  assign countWrite = state_q == ST_DONE && kind_q == K_DECBR && !result_q;
  assign countNew   = cnt;

  logic [15:0] rsp;
  logic        rspNull;
  assign rsp     = cirRdata;
  assign rspNull = rsp[RSP_FUNC_HI:RSP_FUNC_LO] == FUNC_NULL;

  // Words still to skip; a full-format index word announces its own
  logic [3:0]  skipLeft;
  assign skipLeft = remain_q - 4'h1 + ((kind_q == K_SETBYTE
    && remain_q == eaCnt_q && flagWr.mode[5:3] == EA_INDEX
    && fetchData[EXT_FULL_BIT]) ? sizeWords(fetchData[EXT_BD_HI:EXT_BD_LO])
    + sizeWords(fetchData[EXT_OD_HI:EXT_OD_LO]) : 4'h0);

  // Instruction sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q          <= ST_IDLE;
      kind_q           <= K_SETBYTE;
      opWord_q         <= 16'h0000;
      scanPtr_q        <= START_RESET;
      dispAddr_q       <= START_RESET;
      disp_q           <= 16'h0000;
      remain_q         <= 4'h0;
      eaCnt_q          <= 4'h0;
      result_q         <= 1'b0;
      nextPc_q         <= START_RESET;
      fetchReq         <= 1'b0;
      fetchAddr        <= START_RESET;
      cirReqValid      <= 1'b0;
      cirReq           <= '0;
      coprocIdentifier <= 3'h0;
      serviceReq       <= 1'b0;
      servicePrim      <= 16'h0000;
      flagWrite        <= 1'b0;
      flagWr           <= '0;
      trapStart        <= 1'b0;
      protoViolation   <= 1'b0;
      illegalInsn      <= 1'b0;
    end else begin
      flagWrite      <= 1'b0;
      trapStart      <= 1'b0;
      protoViolation <= 1'b0;
      illegalInsn    <= 1'b0;
      fetchAddr      <= scanPtr_q;
      unique case (state_q)
        ST_IDLE: begin
          if (startCmd) begin
            scanPtr_q <= startPc_q;
            fetchAddr <= startPc_q;
            fetchReq  <= 1'b1;
            state_q   <= ST_FOPC;
          end
        end
        ST_FOPC: begin
          if (fetchAck) begin
            fetchReq  <= 1'b0;
            opWord_q  <= fetchData;
            scanPtr_q <= scanPtr_q + WORD_STEP;
            state_q   <= ST_DEC;
          end
        end
        ST_DEC: begin
          coprocIdentifier <= opWord_q[OP_ID_HI:OP_ID_LO];
          fetchReq         <= 1'b1;
          state_q          <= ST_FSEL;
          if (opWord_q[OP_LINE_HI:OP_LINE_LO] != LINE_COPROC) begin
            fetchReq    <= 1'b0;
            illegalInsn <= 1'b1;
            state_q     <= ST_IDLE;
          end else if (opWord_q[OP_SUB_HI:OP_SUB_LO] == SUB_DECBR) begin
            kind_q   <= K_DECBR;
            remain_q <= {1'b0, cpExt_q} + 4'h1;
          end else if (opWord_q[OP_SUB_HI:OP_SUB_LO] == SUB_TRAP) begin
            kind_q <= K_TRAP;
            unique case (opWord_q[OP_LOW_HI:OP_LOW_LO])
              TRAP_ONE:  remain_q <= {1'b0, cpExt_q} + 4'h1;
              TRAP_TWO:  remain_q <= {1'b0, cpExt_q} + 4'h2;
              TRAP_ZERO: remain_q <= {1'b0, cpExt_q};
              default: begin
                fetchReq    <= 1'b0;
                illegalInsn <= 1'b1;
                state_q     <= ST_IDLE;
              end
            endcase
          end else if (opWord_q[OP_TYPE_HI:OP_TYPE_LO] == TYPE_SETBYTE) begin
            kind_q      <= K_SETBYTE;
            flagWr.mode <= opWord_q[OP_EA_HI:OP_EA_LO];
            flagWr.ext  <= 16'h0000;
            eaCnt_q     <= eaWords(opWord_q[OP_EA_HI:OP_EA_LO]);
            remain_q    <= {1'b0, cpExt_q}
                           + eaWords(opWord_q[OP_EA_HI:OP_EA_LO]);
          end else begin
            fetchReq    <= 1'b0;
            illegalInsn <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
        ST_FSEL: begin
          if (fetchAck) begin
            fetchReq     <= 1'b0;
            scanPtr_q    <= scanPtr_q + WORD_STEP;
            cirReqValid  <= 1'b1;
            cirReq.we    <= 1'b1;
            cirReq.resp  <= 1'b0;
            cirReq.data  <= fetchData;
            state_q      <= ST_WCOND;
          end
        end
        ST_WCOND: begin
          if (cirAck) begin
            cirReq.we   <= 1'b0;
            cirReq.resp <= 1'b1;
            cirReq.data <= 16'h0000;
            state_q     <= ST_RRESP;
          end
        end
        ST_RRESP: begin
          if (cirAck) begin
            cirReqValid <= 1'b0;
            if (rspNull && !rsp[RSP_AGAIN]) begin
              result_q <= rsp[RSP_RESULT];
              fetchReq <= remain_q != 4'h0;
              state_q  <= (remain_q != 4'h0) ? ST_SKIP : ST_DONE;
            end else if (rspNull) begin
              cirReqValid <= 1'b1;
            end else if (!rsp[RSP_AGAIN]) begin
              protoViolation <= 1'b1;
              state_q        <= ST_IDLE;
            end else begin
              serviceReq  <= 1'b1;
              servicePrim <= rsp;
              state_q     <= ST_SVC;
            end
          end
        end
        ST_SVC: begin
          if (serviceDone) begin
            serviceReq  <= 1'b0;
            cirReqValid <= 1'b1;
            state_q     <= ST_RRESP;
          end
        end
        ST_SKIP: begin
          if (fetchAck) begin
            scanPtr_q <= scanPtr_q + WORD_STEP;
            fetchAddr <= scanPtr_q + WORD_STEP;
            remain_q  <= skipLeft;
            if (kind_q == K_SETBYTE && remain_q == eaCnt_q) begin
              flagWr.ext <= fetchData;
              eaCnt_q    <= 4'h0;
            end
            if (kind_q == K_DECBR && remain_q == 4'h1) begin
              disp_q     <= fetchData;
              dispAddr_q <= scanPtr_q;
            end
            if (skipLeft == 4'h0) begin
              fetchReq <= 1'b0;
              state_q  <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_q  <= ST_IDLE;
          nextPc_q <= scanPtr_q;
          unique case (kind_q)
            K_SETBYTE: begin
              flagWrite    <= 1'b1;
              flagWr.value <= result_q ? BYTE_TRUE : BYTE_FALSE;
            end
            K_DECBR: begin
              if (!result_q && !decDone) begin
                nextPc_q <= dispAddr_q
                            + {{16{disp_q[15]}}, disp_q};
              end
            end
            K_TRAP: begin
              trapStart <= result_q;
            end
          endcase
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: verification/cco_coproc_cond_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cco_coproc_cond_assertions
  import cco_pkg::*;
(
  input wire logic         clock,
  input wire logic         rst,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_ack_o,
  input wire logic         fetchReq,
  input wire logic [31:0]  fetchAddr,
  input wire logic         fetchAck,
  input wire logic         cirReqValid,
  input wire cco_cir_req_s cirReq,
  input wire logic         cirAck,
  input wire logic [15:0]  cirRdata,
  input wire logic         serviceReq,
  input wire logic         serviceDone,
  input wire logic         flagWrite,
  input wire cco_flag_wr_s flagWr,
  input wire logic         trapStart,
  input wire logic         protoViolation,
  input wire logic         illegalInsn
);
  logic lastRes_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  always_ff @(posedge clock) begin
    if (rst)
      lastRes_q <= 1'b0;
    else if (cirAck && cirReq.resp)
      lastRes_q <= cirRdata[0];
  end

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_fetch_hold: assert property (fetchReq && !fetchAck
    |=> fetchReq && $stable(fetchAddr))
    else $error("fetch request dropped early");
  a_cir_hold: assert property (
    cirReqValid && !cirAck |=> cirReqValid && $stable(cirReq))
    else $error("interface access dropped early");
  a_svc_cause: assert property (
    cirAck && cirReq.resp && cirRdata[15] && cirRdata[12:8] != 5'h00
    |-> ##[1:4] serviceReq)
    else $error("service primitive not served");
  a_svc_hold: assert property (serviceReq && !serviceDone |=> serviceReq)
    else $error("service request dropped early");
  a_proto_cause: assert property (
    cirAck && cirReq.resp && !cirRdata[15] && cirRdata[12:8] != 5'h00
    |-> ##[1:4] protoViolation)
    else $error("protocol violation missed");
  a_flag_byte: assert property (
    flagWrite |-> flagWr.value == {8{lastRes_q}})
    else $error("flag byte does not follow result");
  a_trap_true: assert property (trapStart |-> lastRes_q)
    else $error("trap taken on false result");
  a_ill_quiet: assert property (
    illegalInsn |-> !cirReqValid && !$past(cirReqValid))
    else $error("interface touched on illegal opcode");
endmodule

bind cco_coproc_cond cco_coproc_cond_assertions chk (
  .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
  .fetchAck(fetchAck), .cirReqValid(cirReqValid), .cirReq(cirReq),
  .cirAck(cirAck), .cirRdata(cirRdata), .serviceReq(serviceReq),
  .serviceDone(serviceDone), .flagWrite(flagWrite), .flagWr(flagWr),
  .trapStart(trapStart), .protoViolation(protoViolation),
  .illegalInsn(illegalInsn)
);
`default_nettype wire

// file: verification/cco_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module cco_far_model
  import cco_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         fetchReq,
  input  wire logic [31:0]  fetchAddr,
  output logic              fetchAck,
  output logic      [15:0]  fetchData,
  input  wire logic         cirReqValid,
  input  wire cco_cir_req_s cirReq,
  output logic              cirAck,
  output logic      [15:0]  cirRdata,
  input  wire logic         serviceReq,
  output logic              serviceDone
);
  logic [15:0] mem [8];
  logic [15:0] rsp [4];
  logic [15:0] selSeen = 16'h0000;
  logic [1:0]  tick = 2'h0;
  int          rIdx = 0;
  int          slow = 0;
  logic        go;

  initial begin
    fetchAck = 1'b0;
    cirAck = 1'b0;
    serviceDone = 1'b0;
    fetchData = 16'h0000;
    cirRdata = 16'h0000;
  end

  // Slow mode answers in one cycle of four only
  assign go = slow == 0 || tick == 2'h0;

  always @(posedge clock) begin
    tick <= tick + 2'h1;
    fetchAck <= fetchReq && !fetchAck && go;
    serviceDone <= serviceReq && !serviceDone && go;
    cirAck <= cirReqValid && !cirAck && go;
    // Lines not being answered toggle so stale data never looks valid
    fetchData <= ~fetchData;
    cirRdata <= ~cirRdata;
    if (fetchReq && !fetchAck && go)
      fetchData <= mem[fetchAddr[3:1]];
    if (cirReqValid && !cirAck && go) begin
      if (cirReq.we)
        selSeen <= cirReq.data;
      else begin
        cirRdata <= rsp[rIdx[1:0]];
        rIdx <= rIdx + 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/cco_coproc_cond_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cco_coproc_cond_tb_top
  import cco_pkg::*;
;
  logic         clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0]   wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o, fetchAddr, q, ev;
  logic         fetchReq, fetchAck, cirReqValid, cirAck, serviceReq;
  logic         serviceDone, flagWrite, trapStart, protoViolation, illegalInsn;
  logic [15:0]  fetchData, cirRdata, servicePrim;
  logic [2:0]   coprocIdentifier, idSeen;
  cco_cir_req_s cirReq;
  cco_flag_wr_s flagWr, flagSeen;
  int           miscompares = 0;
  int           checks = 0;
  int           nFlag = 0, nTrap = 0, nProto = 0, nIll = 0, nWr = 0, nSvc = 0;

  cco_coproc_cond uut (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchAck(fetchAck), .fetchData(fetchData), .cirReqValid(cirReqValid),
    .cirReq(cirReq), .coprocIdentifier(coprocIdentifier), .cirAck(cirAck),
    .cirRdata(cirRdata), .serviceReq(serviceReq), .servicePrim(servicePrim),
    .serviceDone(serviceDone), .flagWrite(flagWrite), .flagWr(flagWr),
    .trapStart(trapStart), .protoViolation(protoViolation),
    .illegalInsn(illegalInsn));
  cco_far_model far (
    .clock(clock), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchAck(fetchAck), .fetchData(fetchData), .cirReqValid(cirReqValid),
    .cirReq(cirReq), .cirAck(cirAck), .cirRdata(cirRdata),
    .serviceReq(serviceReq), .serviceDone(serviceDone));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (flagWrite === 1'b1) begin
      nFlag++;
      flagSeen = flagWr;
    end
    nTrap += int'(trapStart === 1'b1);
    nProto += int'(protoViolation === 1'b1);
    nIll += int'(illegalInsn === 1'b1);
    nSvc += int'(serviceDone === 1'b1 && serviceReq === 1'b1);
    if (cirReqValid === 1'b1 && cirAck === 1'b1 && cirReq.we === 1'b1) begin
      nWr++;
      idSeen = coprocIdentifier;
    end
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      chk("bus ack", 32'h0, 32'h1);
      end_of_test();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask

  task automatic ld(input logic [15:0] w [6], input logic [15:0] r [4]);
    for (int i = 0; i < 6; i++)
      far.mem[i] = w[i];
    for (int i = 0; i < 4; i++)
      far.rsp[i] = r[i];
    far.rIdx = 0;
  endtask

  // Runs one instruction from 0x100 and leaves its events in ev
  task automatic run(input logic [31:0] cfg);
    int n;
    wb(REG_EVCLR, 1'b1, 32'h0000_000f, q);
    wb(REG_CONFIG, 1'b1, cfg, q);
    wb(REG_START, 1'b1, 32'h0000_0100, q);
    wb(REG_CTRL, 1'b1, 32'h0000_0001, q);
    n = 0;
    do begin
      wb(REG_STATUS, 1'b0, 32'h0, q);
      n++;
    end while (q[8:0] !== 9'h001 && n < 300);
    if (q[8:0] !== 9'h001) begin
      chk("finish", 32'h0, 32'h1);
      end_of_test();
    end
    wb(REG_EVENTS, 1'b0, 32'h0, ev);
  endtask

  task automatic s_regs();
    wb(REG_STATUS, 1'b0, 32'h0, q);
    chk("status", q, {20'h0, K_SETBYTE, ST_IDLE});
    wb(REG_EVENTS, 1'b0, 32'h0, q);
    chk("events", q, 32'h0);
    wb(8'h40, 1'b1, 32'hffff_ffff, q);
    wb(8'h40, 1'b0, 32'h0, q);
    chk("unmapped", q, 32'h0);
  endtask

  task automatic s_set();
    ld('{16'hf640, 16'h0012, 0, 0, 0, 0}, '{16'h0001, 0, 0, 0});
    run(32'h0);
    chk("sel", far.selSeen, 32'h0012);
    chk("coproc_identifier", idSeen, 32'h3);
    chk("true", flagSeen.value, 32'hff);
    chk("mode", flagSeen.mode, 32'h0);
    wb(REG_NEXTPC, 1'b0, 32'h0, q);
    chk("next", q, 32'h104);
    // Service, come-again null, then false; one coprocessor word first
    ld('{16'hf26d, 16'h0005, 16'haaaa, 16'h1234, 0, 0},
       '{16'h8105, 16'h8000, 16'h0000, 0});
    nSvc = 0;
    run(32'h1);
    chk("svc", nSvc, 1);
    chk("prim", servicePrim, 32'h8105);
    chk("false", flagSeen.value, 32'h0);
    chk("eaword", flagSeen.ext, 32'h1234);
    chk("mode2", flagSeen.mode, 32'h2d);
    chk("cpid2", idSeen, 32'h1);
    chk("flags", nFlag, 2);
    wb(REG_NEXTPC, 1'b0, 32'h0, q);
    chk("next2", q, 32'h108);
  endtask

  task automatic s_dec();
    logic [2:0]  rg [3] = '{3'h7, 3'h0, 3'h3};
    logic [15:0] c0 [3] = '{16'h0005, 16'h0002, 16'h0000};
    logic [15:0] ce [3] = '{16'h0005, 16'h0001, 16'hffff};
    logic [31:0] pe [3] = '{32'h106, 32'h0f4, 32'h106};
    for (int i = 0; i < 3; i++) begin
      wb(REG_COUNT0 + {3'h0, rg[i], 2'h0}, 1'b1, {16'h0, c0[i]}, q);
      ld('{{13'h1e49, rg[i]}, 16'h0007, 16'hfff0, 0, 0, 0},
         '{(i == 0) ? 16'h0001 : 16'h0000, 0, 0, 0});
      run(32'h0);
      wb(REG_COUNT0 + {3'h0, rg[i], 2'h0}, 1'b0, 32'h0, q);
      chk("count", q[15:0], ce[i]);
      wb(REG_NEXTPC, 1'b0, 32'h0, q);
      chk("target", q, pe[i]);
    end
  endtask

  task automatic s_trap();
    logic [2:0] om [3] = '{TRAP_ONE, TRAP_TWO, TRAP_ZERO};
    int         nw [3] = '{1, 2, 0};
    int         t0;
    far.slow = 1;
    for (int i = 0; i < 6; i++) begin
      t0 = nTrap;
      ld('{{13'h1e4f, om[i % 3]}, 16'h0021, 16'h1111, 16'h2222, 0, 0},
         '{16'(i / 3), 0, 0, 0});
      run(32'h0);
      chk("trap", nTrap - t0, i / 3);
      chk("trapev", ev[EV_TRAP], 32'(i / 3));
      wb(REG_NEXTPC, 1'b0, 32'h0, q);
      if (i < 3)
        chk("skip", q, 32'h104 + 32'(2 * nw[i]));
    end
    far.slow = 0;
  endtask

  task automatic s_bad();
    logic [2:0] om [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
    int         w0;
    int         i0;
    for (int i = 0; i < 5; i++) begin
      w0 = nWr;
      i0 = nIll;
      ld('{{13'h1e4f, om[i]}, 16'h0021, 0, 0, 0, 0}, '{16'h0001, 0, 0, 0});
      run(32'h0);
      chk("illegal", nIll - i0, 1);
      chk("nocir", nWr - w0, 0);
      chk("illev", ev[EV_ILLEGAL], 32'h1);
    end
  endtask

  task automatic s_proto();
    int p0;
    p0 = nProto;
    wb(REG_EVEN, 1'b1, 32'h8, q);
    ld('{16'hf640, 16'h0001, 0, 0, 0, 0}, '{16'h0105, 0, 0, 0});
    run(32'h0);
    chk("proto", nProto - p0, 1);
    chk("protoev", ev[EV_PROTO], 32'h1);
    chk("masked", irq, 32'h0);
    wb(REG_EVEN, 1'b1, 32'h4, q);
    chk("irqon", irq, 32'h1);
    wb(REG_EVCLR, 1'b1, 32'h4, q);
    chk("irqclr", irq, 32'h0);
    wb(REG_EVENTS, 1'b0, 32'h0, q);
    chk("cleared", q, 32'h0);
  endtask

  initial begin
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    s_regs();
    s_set();
    s_dec();
    s_trap();
    s_bad();
    s_proto();
    end_of_test();
  end
endmodule
`default_nettype wire
